// ---- design/phy_ctl_regs.svh ----
// Register offsets, field positions, reset values and counts
// Assumes inclusion by the management and data-path design
`ifndef PHY_CTL_REGS_SVH
`define PHY_CTL_REGS_SVH
`define REG_CTRL   5'h00
`define REG_STAT   5'h01
`define REG_ID_HI  5'h02
`define REG_ID_LO  5'h03
`define REG_ADV    5'h04
`define REG_LPA    5'h05
`define REG_EXP    5'h06
`define REG_NP     5'h07
`define REG_LPNP   5'h08
`define REG_RXERR  5'h15
`define REG_INTR   5'h1b
`define REG_DIAG   5'h1d
`define REG_PCTL1  5'h1e
`define REG_PCTL2  5'h1f
`define CB_RESET   15
`define CB_LOOP    14
`define CB_SPEED   13
`define CB_ANEN    12
`define CB_PDOWN   11
`define CB_ISO     10
`define CB_RESTART 9
`define CB_DUPLEX  8
`define CB_COLTEST 7
`define CB_TXDIS   0
`define STAT_BASE  16'h7848
`define STAT_ANDONE 5
`define STAT_LINK  2
`define ADV_RST    16'h01e1
`define ADV_10M    16'h0060
`define NP_RST     16'h2001
`define PCTL2_RST  16'h0400
`define STRAP_MII  3'h6
`define STRAP_RMII 3'h5
`define STRAP_WAIT 2'h3
`define OP_READ    2'h2
`define OP_WRITE   2'h1
`endif

// ---- design/phy_ctl_pkg.sv ----
// Types shared by the control block
// Assumes nothing of its surroundings
package phy_ctl_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_MII    = 3'b010,
    MODE_RMII   = 3'b100
  } b2b_mode_t;
  typedef enum logic [3:0] {
    MD_HUNT = 4'b0001,
    MD_HDR  = 4'b0010,
    MD_TA   = 4'b0100,
    MD_DATA = 4'b1000
  } mdio_st_t;
endpackage

// ---- design/phy_control_back_to_back.sv ----
// Management registers, strap modes and back-to-back data path
// Assumes pins arrive asynchronous; line side runs on clk
//
// Overview of operation
// - Strap 110 sampled at reset selects MII back-to-back mode.
// - MII receive clock, valid and nibble drive the partner's transmit.
// - Strap 101 sampled at reset selects RMII back-to-back mode.
// - RMII carrier-valid and dibit drive the partner's transmit inputs.
// - Copper side in RMII drives receive bit 2 with energy detect.
// - In RMII, high transmit bit 2 drops line_tx_enable only; MII outputs stay driven.
// - Register map with reserved holes as listed.
// - Control bit 15 is a self-clearing software reset.
// - Control bit 13 selects 100 or 10, ignored under autoneg.
// - Control bit 12 enables autoneg; its result overrides duplex, and speed outside back-to-back mode.
// - Speed, autoneg enable and isolate reset from strap pins.
// - Control bit 10 isolates the device from MII and transmit pair.
// - Control bit 9 restarts autoneg and clears itself.
// - Control bit 11 powers down all but management.
// - In back-to-back mode copper never runs or advertises 10 Mbps.
`timescale 1ns/1ps
`include "phy_ctl_regs.svh"

module tx_nibble_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wptr_ff;
  logic [AW-1:0]    rptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data  = mem_ff[rptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      count_ff <= '0;
    end else if (flush) begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == AW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == AW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module phy_control_back_to_back
  import phy_ctl_pkg::*;
#(
  parameter logic [4:0]  PHY_ADDR   = 5'h01,
  parameter logic [15:0] ID_HIGH    = 16'h1234, // Arbitrary value
  parameter logic [15:0] ID_LOW     = 16'h5678, // Arbitrary value
  parameter bit          COPPER     = 1'b1,
  parameter int          FIFO_DEPTH = 8
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe_n,
  input  wire logic [2:0] config_strap,
  input  wire logic       speed_strap,
  input  wire logic       autoneg_default_strap,
  input  wire logic       isolate_strap,
  input  wire logic       duplex_strap,
  input  wire logic       tx_clk,
  input  wire logic       tx_en,
  input  wire logic [3:0] txd,
  output logic            rx_clk,
  output logic            rx_dv,
  output logic [3:0]      rxd,
  output logic            mii_oe_n,
  input  wire logic       line_energy,
  input  wire logic       line_rx_valid,
  input  wire logic [3:0] line_rx_data,
  output logic            line_tx_valid,
  output logic [3:0]      line_tx_data,
  input  wire logic       line_tx_ready,
  output logic            line_tx_enable,
  input  wire logic       an_done,
  input  wire logic       an_result_100,
  input  wire logic       an_result_full,
  input  wire logic       link_up,
  output logic            speed_100,
  output logic            full_duplex,
  output logic            loopback,
  output logic            an_restart,
  output logic            powered_down
);
  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  localparam int NPIN = 16;
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] s1_ff;
  logic [NPIN-1:0] s2_ff;
  logic [1:0]      s3_ff;
  logic            mdc_rise;
  logic            txc_rise;
  logic            mdio_s;
  logic            txen_s;
  logic [3:0]      txd_s;
  logic [2:0]      cfg_s;
  logic [3:0]      straps_s;
  logic            energy_s;

  function automatic logic rise(input logic now, input logic was);
    return now & ~was;
  endfunction

  assign pins = {mdc, tx_clk, mdio_in, tx_en, txd, config_strap,
                 speed_strap, autoneg_default_strap, isolate_strap,
                 duplex_strap, line_energy};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff[15:14];
    end
  end

  assign mdc_rise = rise(s2_ff[15], s3_ff[1]);
  assign txc_rise = rise(s2_ff[14], s3_ff[0]);
  assign mdio_s   = s2_ff[13];
  assign txen_s   = s2_ff[12];
  assign txd_s    = s2_ff[11:8];
  assign cfg_s    = s2_ff[7:5];
  assign straps_s = s2_ff[4:1];
  assign energy_s = s2_ff[0];

  // ****************************************************
  // Strap capture after reset release
  // ****************************************************
  logic [1:0] strap_cnt_ff;
  logic       strap_done_ff;
  logic       strap_take;
  logic [3:0] strap_ff;
  b2b_mode_t  mode_ff;
  logic       b2b;

  assign strap_take = ~strap_done_ff & (strap_cnt_ff == `STRAP_WAIT);
  assign b2b        = (mode_ff != MODE_NORMAL);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_cnt_ff  <= '0;
      strap_done_ff <= 1'b0;
      strap_ff      <= '0;
      mode_ff       <= MODE_NORMAL;
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_take) begin
        strap_done_ff <= 1'b1;
        strap_ff      <= straps_s;
        if (cfg_s == `STRAP_MII) begin
          mode_ff <= MODE_MII;
        end else if (cfg_s == `STRAP_RMII) begin
          mode_ff <= MODE_RMII;
        end else begin
          mode_ff <= MODE_NORMAL;
        end
      end
    end
  end

  // ****************************************************
  // Management frame engine
  // ****************************************************
  mdio_st_t    md_ff;
  logic [4:0]  cnt_ff;
  logic [12:0] hdr_ff;
  logic [12:0] nxt_hdr;
  logic        mine_ff;
  logic        is_rd_ff;
  logic [15:0] sh_ff;
  logic        wr_stb_ff;
  logic [4:0]  wr_addr_ff;
  logic [4:0]  reg_addr_ff;
  logic        mdio_out_ff;
  logic        mdio_oe_n_ff;
  logic        hdr_ok;
  logic [15:0] rd_val;

  assign nxt_hdr = {hdr_ff[11:0], mdio_s};
  assign hdr_ok  = nxt_hdr[12] & (nxt_hdr[9:5] == PHY_ADDR);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      md_ff        <= MD_HUNT;
      cnt_ff       <= '0;
      hdr_ff       <= '0;
      mine_ff      <= 1'b0;
      is_rd_ff     <= 1'b0;
      sh_ff        <= '0;
      wr_stb_ff    <= 1'b0;
      wr_addr_ff   <= '0;
      reg_addr_ff  <= '0;
      mdio_out_ff  <= 1'b1;
      mdio_oe_n_ff <= 1'b1;
    end else begin
      wr_stb_ff <= 1'b0;
      if (mdc_rise) begin
        case (md_ff)
          MD_HUNT: begin
            cnt_ff <= '0;
            if (!mdio_s) begin
              md_ff <= MD_HDR;
            end
          end
          MD_HDR: begin
            hdr_ff <= nxt_hdr;
            cnt_ff <= cnt_ff + 5'h1;
            if (cnt_ff == 5'h0c) begin
              md_ff       <= MD_TA;
              cnt_ff      <= '0;
              reg_addr_ff <= nxt_hdr[4:0];
              is_rd_ff    <= (nxt_hdr[11:10] == `OP_READ);
              mine_ff     <= hdr_ok &
                             ((nxt_hdr[11:10] == `OP_READ) |
                              (nxt_hdr[11:10] == `OP_WRITE));
            end
          end
          MD_TA: begin
            cnt_ff <= cnt_ff + 5'h1;
            if (cnt_ff == 5'h00) begin
              sh_ff <= rd_val;
              if (mine_ff && is_rd_ff) begin
                mdio_out_ff  <= 1'b0;
                mdio_oe_n_ff <= 1'b0;
              end
            end else begin
              md_ff       <= MD_DATA;
              cnt_ff      <= '0;
              mdio_out_ff <= sh_ff[15];
              sh_ff       <= {sh_ff[14:0], 1'b0};
            end
          end
          MD_DATA: begin
            cnt_ff <= cnt_ff + 5'h1;
            if (is_rd_ff) begin
              mdio_out_ff <= sh_ff[15];
              sh_ff       <= {sh_ff[14:0], 1'b0};
            end else begin
              sh_ff <= {sh_ff[14:0], mdio_s};
            end
            if (cnt_ff == 5'h0f) begin
              md_ff        <= MD_HUNT;
              mdio_out_ff  <= 1'b1;
              mdio_oe_n_ff <= 1'b1;
              wr_stb_ff    <= mine_ff & ~is_rd_ff;
              wr_addr_ff   <= reg_addr_ff;
            end
          end
          default: begin
            md_ff <= MD_HUNT;
          end
        endcase
      end
    end
  end

  // ****************************************************
  // Register file
  // ****************************************************
  logic [15:0] ctrl_ff;
  logic [15:0] adv_ff;
  logic [15:0] np_ff;
  logic [15:0] intr_ff;
  logic [15:0] diag_ff;
  logic [15:0] pctl1_ff;
  logic [15:0] pctl2_ff;
  logic [15:0] rxerr_ff;
  logic        soft_rst_ff;
  logic        pd_out_ff;
  logic        an_restart_ff;
  logic        soft_rst;
  logic        drop;
  logic [15:0] ctrl_rst;

  assign soft_rst = wr_stb_ff & (wr_addr_ff == `REG_CTRL) &
                    sh_ff[`CB_RESET];
  // Control word built from speed, autoneg, isolate, duplex straps
  function automatic logic [15:0] ctrl_from(input logic [3:0] s);
    return {2'b00, s[3], s[2], 1'b0, s[1], 1'b0, s[0], 8'h00};
  endfunction

  assign ctrl_rst = ctrl_from(strap_ff);

  always_comb begin
    case (hdr_ff[4:0])
      `REG_CTRL:  rd_val = ctrl_ff;
      `REG_STAT:  rd_val = `STAT_BASE |
                           (16'(an_done) << `STAT_ANDONE) |
                           (16'(link_up) << `STAT_LINK);
      `REG_ID_HI: rd_val = ID_HIGH;
      `REG_ID_LO: rd_val = ID_LOW;
      `REG_ADV:   rd_val = b2b ? (adv_ff & ~`ADV_10M) : adv_ff;
      `REG_NP:    rd_val = np_ff;
      `REG_RXERR: rd_val = rxerr_ff;
      `REG_INTR:  rd_val = intr_ff;
      `REG_DIAG:  rd_val = diag_ff;
      `REG_PCTL1: rd_val = pctl1_ff;
      `REG_PCTL2: rd_val = pctl2_ff;
      default:    rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_ff       <= '0;
      adv_ff        <= `ADV_RST;
      np_ff         <= `NP_RST;
      intr_ff       <= '0;
      diag_ff       <= '0;
      pctl1_ff      <= '0;
      pctl2_ff      <= `PCTL2_RST;
      soft_rst_ff   <= 1'b0;
      pd_out_ff     <= 1'b0;
      an_restart_ff <= 1'b0;
    end else begin
      soft_rst_ff   <= soft_rst;
      pd_out_ff     <= soft_rst_ff | ctrl_ff[`CB_PDOWN];
      an_restart_ff <= 1'b0;
      if (strap_take) begin
        ctrl_ff <= ctrl_from(straps_s);
      end else if (soft_rst) begin
        ctrl_ff       <= ctrl_rst;
        adv_ff        <= `ADV_RST;
        np_ff         <= `NP_RST;
        intr_ff       <= '0;
        diag_ff       <= '0;
        pctl1_ff      <= '0;
        pctl2_ff      <= `PCTL2_RST;
      end else if (wr_stb_ff) begin
        case (wr_addr_ff)
          `REG_CTRL: begin
            ctrl_ff <= sh_ff & 16'h7d81;
            an_restart_ff <= sh_ff[`CB_RESTART];
          end
          `REG_ADV:   adv_ff   <= sh_ff;
          `REG_NP:    np_ff    <= sh_ff;
          `REG_INTR:  intr_ff  <= sh_ff;
          `REG_DIAG:  diag_ff  <= sh_ff;
          `REG_PCTL1: pctl1_ff <= sh_ff;
          `REG_PCTL2: pctl2_ff <= sh_ff;
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxerr_ff <= '0;
    end else if (soft_rst) begin
      rxerr_ff <= '0;
    end else if (drop && rxerr_ff != 16'hffff) begin
      rxerr_ff <= rxerr_ff + 16'h0001;
    end
  end

  // ****************************************************
  // Data path
  // ****************************************************
  logic       pdown;
  logic       iso;
  logic       active;
  logic       f_in_ready;
  logic       f_out_valid;
  logic [3:0] f_out_data;
  logic       f_out_ready;
  logic       push;
  logic [3:0] push_data;
  logic       ltx_valid_ff;
  logic [3:0] ltx_data_ff;
  logic       ltx_en_ff;
  logic       rx_clk_ff;
  logic       rx_dv_ff;
  logic [3:0] rxd_ff;
  logic       mii_oe_n_ff;
  logic       spd_ff;
  logic       dup_ff;

  assign pdown  = ctrl_ff[`CB_PDOWN];
  assign iso    = ctrl_ff[`CB_ISO];
  assign active = strap_done_ff & ~pdown & ~iso;
  assign push   = active & txc_rise & txen_s;
  assign push_data = (mode_ff == MODE_RMII) ? {2'b00, txd_s[1:0]} : txd_s;
  assign drop   = push & ~f_in_ready;
  assign f_out_ready = ~ltx_valid_ff | line_tx_ready;

  tx_nibble_fifo #(.WIDTH(4), .DEPTH(FIFO_DEPTH)) i_tx_nibble_fifo (
    .clk       (clk),
    .reset     (reset),
    .flush     (soft_rst | ~active),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   (push_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ltx_valid_ff <= 1'b0;
      ltx_data_ff  <= '0;
      ltx_en_ff    <= 1'b0;
    end else begin
      if (!active) begin
        ltx_valid_ff <= 1'b0;
      end else if (f_out_ready) begin
        ltx_valid_ff <= f_out_valid;
        ltx_data_ff  <= f_out_data;
      end
      ltx_en_ff <= active & ~ctrl_ff[`CB_TXDIS] &
                   ~((mode_ff == MODE_RMII) & txd_s[2]);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_clk_ff   <= 1'b0;
      rx_dv_ff    <= 1'b0;
      rxd_ff      <= '0;
      mii_oe_n_ff <= 1'b1;
    end else begin
      mii_oe_n_ff <= ~active;
      rx_clk_ff   <= active & (mode_ff != MODE_RMII) & ~rx_clk_ff;
      rx_dv_ff    <= active & line_rx_valid;
      if (!active) begin
        rxd_ff <= '0;
      end else if (mode_ff == MODE_RMII) begin
        rxd_ff <= {1'b0, COPPER ? energy_s : 1'b0, line_rx_data[1:0]};
      end else begin
        rxd_ff <= line_rx_data;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      spd_ff <= 1'b0;
      dup_ff <= 1'b0;
    end else begin
      if (b2b) begin
        spd_ff <= 1'b1;
      end else if (ctrl_ff[`CB_ANEN]) begin
        spd_ff <= an_result_100;
      end else begin
        spd_ff <= ctrl_ff[`CB_SPEED];
      end
      dup_ff <= ctrl_ff[`CB_ANEN] ? an_result_full : ctrl_ff[`CB_DUPLEX];
    end
  end

  assign mdio_out       = mdio_out_ff;
  assign mdio_oe_n      = mdio_oe_n_ff;
  assign rx_clk         = rx_clk_ff;
  assign rx_dv          = rx_dv_ff;
  assign rxd            = rxd_ff;
  assign mii_oe_n       = mii_oe_n_ff;
  assign line_tx_valid  = ltx_valid_ff;
  assign line_tx_data   = ltx_data_ff;
  assign line_tx_enable = ltx_en_ff;
  assign speed_100      = spd_ff;
  assign full_duplex    = dup_ff;
  assign loopback       = ctrl_ff[`CB_LOOP];
  assign an_restart     = an_restart_ff;
  assign powered_down   = pd_out_ff;
endmodule

// ---- bench/mgmt_host.sv ----
// Management station model driving the mdc/mdio pins
// Assumes the bench resolves the mdio wire with a pull-up
`timescale 1ns/1ps
module mgmt_host (
  output logic        mdc,
  output logic        mdio_drv,
  input  wire logic   mdio_in,
  output logic [15:0] rdata,
  output logic        rd_done
);
  // ****************
  // Frame engine
  // ****************
  logic host_oe;
  logic host_bit;
  assign mdio_drv = host_oe ? host_bit : 1'b1;
  initial begin
    mdc = 1'b0;
    host_oe = 1'b0;
    host_bit = 1'b1;
    rdata = 16'h0000;
    rd_done = 1'b0;
  end
  // Clock stands still between frames, 400 ns period inside
  task automatic frame(input logic rd, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd);
    logic [31:0] f;
    f = {2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
    for (int i = 0; i < 32; i++) begin
      host_oe = !(rd && i >= 14);
      host_bit = f[31-i];
      #200 mdc = 1'b1;
      if (rd && i >= 16) rdata[31-i] = mdio_in;
      #200 mdc = 1'b0;
    end
    host_oe = 1'b0;
    if (rd) begin
      rd_done = 1'b1;
      #1 rd_done = 1'b0;
    end
  endtask
endmodule

// ---- bench/phy_control_back_to_back_chk.sv ----
// Port-level assertions for the control block
// Assumes binding to phy_control_back_to_back
`timescale 1ns/1ps
module phy_ctl_chk (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       line_rx_valid,
  input wire logic [3:0] line_rx_data,
  input wire logic       rx_clk,
  input wire logic       rx_dv,
  input wire logic [3:0] rxd,
  input wire logic       mii_oe_n,
  input wire logic       line_tx_valid,
  input wire logic [3:0] line_tx_data,
  input wire logic       line_tx_ready,
  input wire logic       line_tx_enable,
  input wire logic       an_restart,
  input wire logic       powered_down,
  input wire logic       mdio_out,
  input wire logic       mdio_oe_n
);
  // ****************
  // Assertions
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_rx_dv_follow: assert property (!mii_oe_n && !$past(mii_oe_n)
    |-> rx_dv == $past(line_rx_valid)) else $error("rx_dv lag");
  chk_mii_nibble: assert property (rx_clk != $past(rx_clk) &&
    !mii_oe_n && !$past(mii_oe_n) |-> rxd == $past(line_rx_data))
    else $error("rxd nibble");
  chk_rmii_dibit: assert property (!rx_clk && !$past(rx_clk) &&
    !mii_oe_n && !$past(mii_oe_n) |-> !rxd[3] &&
    rxd[1:0] == $past(line_rx_data[1:0])) else $error("rmii dibit");
  chk_restart_pulse: assert property (an_restart
    |=> !an_restart) else $error("restart not a pulse");
  chk_tx_hold: assert property (line_tx_valid && !line_tx_ready &&
    !mii_oe_n |=> mii_oe_n || (line_tx_valid && $stable(line_tx_data)))
    else $error("tx word dropped");
  chk_pd_tx_off: assert property (powered_down [*2]
    |-> !line_tx_enable) else $error("tx on in power down");
  chk_pd_release: assert property (powered_down [*2]
    |-> mii_oe_n) else $error("pins driven in power down");
  chk_quiet_out: assert property (mii_oe_n [*2]
    |-> !rx_dv && rxd == 4'h0 && !rx_clk) else $error("isolated output");
  chk_mdio_ta: assert property ($fell(mdio_oe_n)
    |-> !mdio_out) else $error("turnaround not zero");
  cov_restart: cover property (an_restart);
  cov_stall: cover property (line_tx_valid && !line_tx_ready);
  cov_read: cover property ($fell(mdio_oe_n));
endmodule
bind phy_control_back_to_back phy_ctl_chk i_phy_ctl_chk (.clk(clk),
  .reset(reset), .line_rx_valid(line_rx_valid),
  .line_rx_data(line_rx_data), .rx_clk(rx_clk), .rx_dv(rx_dv),
  .rxd(rxd), .mii_oe_n(mii_oe_n), .line_tx_valid(line_tx_valid),
  .line_tx_data(line_tx_data), .line_tx_ready(line_tx_ready),
  .line_tx_enable(line_tx_enable), .an_restart(an_restart),
  .powered_down(powered_down), .mdio_out(mdio_out),
  .mdio_oe_n(mdio_oe_n));

// ---- bench/phy_control_back_to_back_tb.sv ----
// Self-checking bench for the control block
// Assumes mgmt_host as station and bench-driven data pins
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module phy_control_back_to_back_tb;
  // ****************
  // Signals and instances
  // ****************
  localparam logic [15:0] IDH = 16'h0abc; // Arbitrary value
  localparam logic [15:0] IDL = 16'h0def; // Arbitrary value
  logic clk = 0, reset = 1, mdc, mdio_in, mdio_out, mdio_oe_n, mdio_drv;
  logic [2:0] config_strap = 0;
  logic speed_strap = 0, autoneg_default_strap = 1, isolate_strap = 0;
  logic duplex_strap = 1, tx_clk = 0, tx_en = 0, rx_clk, rx_dv, mii_oe_n;
  logic [3:0] txd = 0, rxd, line_rx_data = 0, line_tx_data;
  logic line_energy = 0, line_rx_valid = 0, line_tx_valid;
  logic line_tx_ready = 1, line_tx_enable, an_done = 1, an_result_100 = 1;
  logic an_result_full = 0, link_up = 1, speed_100, full_duplex;
  logic loopback, an_restart, powered_down, rd_done;
  logic [15:0] rdata;
  logic [15:0] exp_q[$];
  logic [3:0] tx_q[$];
  logic [15:0] exp_rd;
  logic [3:0] exp_tx;
  int fails = 0, tests_run = 0, cycles = 0, restarts = 0;
  assign mdio_in = mdio_oe_n ? mdio_drv : mdio_out;
  always #25 clk = ~clk;
  mgmt_host i_mgmt_host (.mdc(mdc), .mdio_drv(mdio_drv),
    .mdio_in(mdio_in), .rdata(rdata), .rd_done(rd_done));
  phy_control_back_to_back #(.ID_HIGH(IDH), .ID_LOW(IDL))
  i_phy_control_back_to_back (.clk(clk), .reset(reset), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .config_strap(config_strap), .speed_strap(speed_strap),
    .autoneg_default_strap(autoneg_default_strap),
    .isolate_strap(isolate_strap), .duplex_strap(duplex_strap),
    .tx_clk(tx_clk), .tx_en(tx_en), .txd(txd), .rx_clk(rx_clk),
    .rx_dv(rx_dv), .rxd(rxd), .mii_oe_n(mii_oe_n),
    .line_energy(line_energy), .line_rx_valid(line_rx_valid),
    .line_rx_data(line_rx_data), .line_tx_valid(line_tx_valid),
    .line_tx_data(line_tx_data), .line_tx_ready(line_tx_ready),
    .line_tx_enable(line_tx_enable), .an_done(an_done),
    .an_result_100(an_result_100), .an_result_full(an_result_full),
    .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex),
    .loopback(loopback), .an_restart(an_restart),
    .powered_down(powered_down));
  // ****************
  // Monitors and tasks
  // ****************
  always @(posedge rd_done) begin
    exp_rd = exp_q.pop_front();
    `CHK(rdata, exp_rd)
  end
  always @(posedge clk) begin
    if (line_tx_valid === 1 && line_tx_ready === 1) begin
      exp_tx = tx_q.pop_front();
      `CHK(line_tx_data, exp_tx)
    end
    if (an_restart === 1) restarts++;
    cycles++;
    if (cycles == 60000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] s);
    @(negedge clk) reset = 1;
    config_strap = s;
    repeat (10) @(negedge clk);
    reset = 0;
    repeat (10) @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    i_mgmt_host.frame(1'b0, 5'h01, a, d);
    repeat (8) @(negedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_mgmt_host.frame(1'b1, 5'h01, a, 16'h0000);
    repeat (2) @(negedge clk);
  endtask
  task automatic send(input int n, input logic rmii);
    for (int i = 0; i < n; i++) begin
      @(negedge clk) tx_clk = 0;
      tx_en = 1;
      txd = rmii ? {2'b00, 2'($urandom)} : 4'($urandom);
      tx_q.push_back(txd);
      repeat (4) @(negedge clk);
      tx_clk = 1;
      repeat (4) @(negedge clk);
    end
    tx_en = 0;
    tx_clk = 0;
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    void'($urandom(43));
    do_reset(3'b000);
    rd(5'h00, 16'h1100);
    rd(5'h02, IDH);
    rd(5'h03, IDL);
    rd(5'h01, 16'h786c);
    for (int a = 9; a < 29; a++)
      if (a != 21 && a != 27) begin
        wr(5'(a), 16'hffff);
        rd(5'(a), 16'h0000);
      end
    i_mgmt_host.frame(1'b0, 5'h02, 5'h04, 16'h0000);
    rd(5'h04, 16'h01e1);
    wr(5'h00, 16'h2100);
    `CHK({speed_100, full_duplex}, 2'b11)
    wr(5'h00, 16'h4001);
    `CHK({speed_100, full_duplex, loopback, line_tx_enable}, 4'b0010)
    wr(5'h00, 16'h1200);
    `CHK({speed_100, full_duplex}, 2'b10)
    rd(5'h00, 16'h1000);
    `CHK(restarts, 1)
    wr(5'h00, 16'h0800);
    `CHK({powered_down, mii_oe_n, line_tx_enable}, 3'b110)
    rd(5'h00, 16'h0800);
    wr(5'h00, 16'h0400);
    `CHK({powered_down, mii_oe_n}, 2'b01)
    wr(5'h00, 16'h0000);
    `CHK(mii_oe_n, 1'b0)
    wr(5'h04, 16'h0000);
    wr(5'h00, 16'h8000);
    rd(5'h00, 16'h1100);
    rd(5'h04, 16'h01e1);
    do_reset(3'b110);
    rd(5'h04, 16'h0181);
    wr(5'h00, 16'h0000);
    `CHK(speed_100, 1'b1)
    line_tx_ready = 0;
    send(8, 1'b0);
    repeat (60) @(negedge clk) begin
      {line_rx_valid, line_rx_data} = 5'($urandom);
      line_tx_ready = 1'($urandom);
    end
    line_tx_ready = 1;
    repeat (10) @(negedge clk);
    `CHK(tx_q.size(), 0)
    do_reset(3'b101);
    send(4, 1'b1);
    line_energy = 1;
    repeat (6) @(negedge clk);
    `CHK(rxd[2], 1'b1)
    line_energy = 0;
    txd = 4'h4;
    repeat (6) @(negedge clk);
    `CHK({rxd[2], line_tx_enable}, 2'b00)
    txd = 4'h0;
    repeat (6) @(negedge clk);
    `CHK(line_tx_enable, 1'b1)
    `CHK(tx_q.size(), 0)
    summarize();
  end
endmodule
